// ### bench/edpc_partner.sv
// edpc_partner: line partner model, sends data and error events and an energy level, counts probes
// assumes bench requests change just after rising clock edges
`timescale 1ns/10ps
module edpc_partner
   import edpc_pkg::*;
(
   input  wire logic      clk,        // clock
   input  wire logic      rst_n,      // async reset
   input  wire logic      data_req,   // send one data event
   input  wire logic      err_req,    // send one error event
   input  wire logic      energy_req, // line energy level
   input  edpc_line_out_t line_out,   // device line controls
   output edpc_line_in_t  line_in,    // events toward device
   output logic [7:0]     probes      // probe pulses seen
);
   // events leave as one-cycle strobes, energy as a level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_in <= '0;
         probes  <= 8'h00;
      end else begin
         line_in <= '{data_evt: data_req, err_evt: err_req, energy: energy_req};
         if (line_out.pulse) begin
            probes <= probes + 8'h01;
         end
      end
   end
endmodule // edpc_partner

// ### bench/energy_detect_power_control_test.sv
// energy_detect_power_control_test: register-level bench of edpc_top
// assumes the one slave drives hready; idle timeout shortened to 50 cycles
`timescale 1ns/10ps
module energy_detect_power_control_test
   import edpc_pkg::*;
;
   localparam logic [31:0] A_CTL = {ECR_IDX, 2'b00};
   localparam logic [31:0] A_IST = {IST_IDX, 2'b00};
   localparam logic [31:0] A_IMK = {IMK_IDX, 2'b00};
   logic           clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic           data_req, err_req, energy_req;
   logic [31:0]    haddr, hwdata, hrdata, rd;
   logic [1:0]     htrans;
   logic [2:0]     hsize;
   logic [7:0]     probes, base;
   edpc_line_in_t  line_in;
   edpc_line_out_t line_out;
   int             num_errors, num_checks;

   assign hready = hreadyout;
   always #2 clk = ~clk;

   edpc_top #(.IDLE_CYCLES(50)) i_edpc_top (.clk(clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .line_in(line_in), .line_out(line_out), .irq(irq));
   edpc_partner i_edpc_partner (.clk(clk), .rst_n(rst_n), .data_req(data_req),
      .err_req(err_req), .energy_req(energy_req), .line_out(line_out),
      .line_in(line_in), .probes(probes));

   // closing report
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // compare one value
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // wait for an edge with ready high, bounded
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         $display("ERROR hready expected 1 seen %b", hreadyout);
         give_verdict();
      end
   endtask

   // one single word transfer, address then data phase
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      hsize  <= SIZE_WORD;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      check(name, rd, exp);
   endtask

   // one line event, then let it settle
   task automatic ev(input logic err);
      if (err) begin
         err_req <= 1'b1;
      end else begin
         data_req <= 1'b1;
      end
      @(posedge clk);
      err_req  <= 1'b0;
      data_req <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic bit1(input string name, input logic v, input logic exp);
      check(name, {31'h0, v}, {31'h0, exp});
   endtask

   // main sequence
   initial begin
      clk = 1'b0; rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
      hsize = SIZE_WORD; haddr = 32'h0; hwdata = 32'h0;
      data_req = 1'b0; err_req = 1'b0; energy_req = 1'b0;
      num_errors = 0; num_checks = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk("ctl reset", A_CTL, 32'h6011);
      rchk("status reset", A_IST, 32'h0);
      rchk("mask reset", A_IMK, 32'h0);
      rchk("unmapped", 32'h80, 32'h0);
      bit1("hresp", hresp, 1'b0);
      bit1("rx_power", line_out.rx_power, 1'b1);
      // auto wake on second data event
      bus(A_IMK, 1'b1, 32'h7);
      energy_req <= 1'b1;
      bus(A_CTL, 1'b1, 32'he022);
      ev(1'b0);
      rchk("one event", A_CTL, 32'he022);
      base = probes;
      ev(1'b0);
      rchk("woken", A_CTL, 32'he522);
      rchk("data hit cleared", A_CTL, 32'he422);
      rchk("wake status", A_IST, 32'h5);
      bit1("irq up", irq, 1'b1);
      bit1("drv_on", line_out.drv_on, 1'b1);
      repeat (600) @(posedge clk);
      check("burst", {24'h0, probes - base}, 32'h4);
      // error threshold only flags
      ev(1'b1);
      ev(1'b1);
      rchk("err hit", A_CTL, 32'he622);
      rchk("err hit cleared", A_CTL, 32'he422);
      // auto sleep on line silence
      energy_req <= 1'b0;
      repeat (4) @(posedge clk);
      rchk("asleep", A_CTL, 32'he022);
      bit1("drv_on off", line_out.drv_on, 1'b0);
      bit1("rx_power off", line_out.rx_power, 1'b0);
      bus(A_IST, 1'b1, 32'h7);
      rchk("status cleared", A_IST, 32'h0);
      repeat (2) @(posedge clk);
      bit1("irq down", irq, 1'b0);
      // manual toggle after clearing, masked interrupt, single probe
      bus(A_IMK, 1'b1, 32'h0);
      base = probes;
      bus(A_CTL, 1'b1, 32'hd822);
      rchk("manual up", A_CTL, 32'hcc22);
      rchk("masked status", A_IST, 32'h1);
      bit1("irq masked", irq, 1'b0);
      bus(A_IMK, 1'b1, 32'h1);
      repeat (2) @(posedge clk);
      bit1("irq unmasked", irq, 1'b1);
      repeat (600) @(posedge clk);
      check("single", {24'h0, probes - base}, 32'h1);
      bus(A_CTL, 1'b1, 32'hd822);
      rchk("manual down", A_CTL, 32'hc822);
      bus(A_IST, 1'b1, 32'h1);
      // counters forget after idle time
      bus(A_CTL, 1'b1, 32'he022);
      ev(1'b0);
      repeat (80) @(posedge clk);
      ev(1'b0);
      rchk("idle reset", A_CTL, 32'he022);
      // disabled sensing ignores events
      bus(A_CTL, 1'b1, 32'h6022);
      energy_req <= 1'b1;
      ev(1'b0);
      ev(1'b0);
      rchk("disabled", A_CTL, 32'h6022);
      rchk("no status", A_IST, 32'h0);
      bit1("rx_power on", line_out.rx_power, 1'b1);
      give_verdict();
   end
endmodule // energy_detect_power_control_test

// ### hdl/edpc_evcnt.sv
// edpc_evcnt: saturating event counter with threshold compare
// assumes clr takes priority over inc
`timescale 1ns/10ps
module edpc_evcnt
   import edpc_pkg::*;
(
   input  wire logic            clk,    // clock
   input  wire logic            rst_n,  // async reset
   input  wire logic            clr,    // clear count
   input  wire logic            inc,    // event strobe
   input  wire logic [TH_W-1:0] th,     // threshold
   output logic      [TH_W-1:0] cnt,    // current count
   output logic                 met,    // count at or above th
   output logic                 hit     // this event meets th
);

   logic [TH_W-1:0] cnt_r;
   logic [TH_W-1:0] cnt_nxt;
   logic [TH_W:0]   sum;

   // saturate at all ones so noise cannot wrap the count
   always_comb begin
      sum     = {1'b0, cnt_r} + 1'b1;
      cnt_nxt = cnt_r;
      if (clr) begin
         cnt_nxt = '0;
      end else if (inc && !(&cnt_r)) begin
         cnt_nxt = sum[TH_W-1:0];
      end
   end

   assign cnt = cnt_r;
   assign met = cnt_r >= th;
   assign hit = inc && !clr && (sum >= {1'b0, th});

   // count register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule // edpc_evcnt

// ### hdl/edpc_pkg.sv
// edpc_pkg: constants, types and state of the energy-sense power control
// assumes one 250 MHz clock and an AHB-Lite register slave
// What this block does
// RULE1 - sensing mode only while enable bit set
// RULE2 - software drops crossover when sensing without autoneg
// RULE3 - auto wake once data count reaches threshold
// RULE4 - auto sleep once no line energy
// RULE5 - manual bit toggles power state at once
// RULE6 - software may toggle after clearing interrupt
// RULE7 - burst of four pulses per wake
// RULE8 - burst off gives one pulse per wake
// RULE9 - read-only bit shows power state
// RULE10 - error threshold flag, no action, read clears
// RULE11 - data threshold flag, read clears
// RULE12 - error threshold field bits 7:4, reset 1
// RULE13 - data threshold field bits 3:0, reset 1
// RULE14 - counters reset after two idle seconds
// RULE15 - power change raises maskable interrupt; the drop to down when enable is cleared raises none
// RULE16 - manual bit reads zero once acted upon
package edpc_pkg;

   // register word indices, byte address is four times the index
   localparam logic [29:0] ECR_IDX = 30'h1d;  // energy_control_reg
   localparam logic [29:0] IST_IDX = 30'h1e;  // interrupt status
   localparam logic [29:0] IMK_IDX = 30'h1f;  // interrupt mask

   // energy_control_reg fields
   localparam int ENA_B   = 15;
   localparam int WAKE_B  = 14;
   localparam int SLEEP_B = 13;
   localparam int MAN_B   = 12;
   localparam int BURST_B = 11;
   localparam int PWR_B   = 10;
   localparam int TH_W    = 4;
   localparam int ERRTH_L = 4;
   localparam int DATTH_L = 0;
   localparam int ECR_W   = 16;
   localparam logic [15:0] ECR_RST = 16'h6011;

   // interrupt status and mask layout
   localparam int IRQ_W   = 3;
   localparam int IRQ_PWR = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_DAT = 2;

   // bus constants
   localparam logic [2:0] SIZE_WORD  = 3'h2;
   localparam logic       HRESP_OKAY = 1'b0;

   // timing
   localparam int unsigned CLK_MHZ  = 250;
   localparam int unsigned IDLE_MS  = 2000;
   localparam int unsigned IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ;
   localparam int          IDLE_W   = 29;
   localparam int unsigned GAP_NS   = 400;
   localparam int unsigned GAP_CYC  = GAP_NS * CLK_MHZ / 1000;
   localparam int          GAP_W    = 7;
   localparam logic [2:0]  BURST_N  = 3'h4;
   localparam logic [2:0]  SINGLE_N = 3'h1;

   typedef enum logic [0:0] {
      EDPC_ST_DOWN = 1'b0,
      EDPC_ST_UP   = 1'b1
   } edpc_pwr_t;

   typedef struct packed {
      logic            enable;
      logic            wake;
      logic            sleep;
      logic            manual;
      logic            burst_off;
      logic [TH_W-1:0] err_th;
      logic [TH_W-1:0] data_th;
   } edpc_ctl_t;

   typedef struct packed {
      logic data_evt;
      logic err_evt;
      logic energy;
   } edpc_line_in_t;

   typedef struct packed {
      logic rx_power;
      logic drv_on;
      logic pulse;
   } edpc_line_out_t;

   typedef struct packed {
      edpc_ctl_t        ctl;
      edpc_pwr_t        pwr;
      logic             rx_on;
      logic             err_hit;
      logic             data_hit;
      logic [2:0]       pulses;
      logic             pulse;
      logic [IRQ_W-1:0] int_st;
      logic [IRQ_W-1:0] int_mask;
      logic             irq;
      logic             wr_pend;
      logic             rd_pend;
      logic [29:0]      ap_idx;
      logic [31:0]      hrdata;
      logic             hready;
   } edpc_state_t;

   localparam edpc_ctl_t CTL_RST = '{
      enable:    ECR_RST[ENA_B],
      wake:      ECR_RST[WAKE_B],
      sleep:     ECR_RST[SLEEP_B],
      manual:    ECR_RST[MAN_B],
      burst_off: ECR_RST[BURST_B],
      err_th:    ECR_RST[ERRTH_L +: TH_W],
      data_th:   ECR_RST[DATTH_L +: TH_W]
   };

   localparam edpc_state_t ST_RST = '{
      ctl: CTL_RST, pwr: EDPC_ST_DOWN, rx_on: 1'b1, hready: 1'b1, default: '0
   };

endpackage

// ### hdl/edpc_tick.sv
// edpc_tick: divider giving a one-cycle enable every CYC cycles
// assumes en held high while counting; low restarts the count
`timescale 1ns/10ps
module edpc_tick
   import edpc_pkg::*;
#(
   parameter int unsigned CYC = GAP_CYC,
   parameter int          W   = GAP_W
) (
   input  wire logic clk,    // clock
   input  wire logic rst_n,  // async reset
   input  wire logic en,     // count enable
   output logic      tick    // one-cycle pulse
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // wrap at the end, restart while disabled
   always_comb begin
      cnt_nxt = '0;
      if (en && cnt_r != W'(CYC - 1)) begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   assign tick = en && (cnt_r == W'(CYC - 1));

   // count register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule // edpc_tick

// ### hdl/edpc_top.sv
// edpc_top: energy-sense power control with AHB-Lite registers
// assumes line events are one-cycle strobes synchronous to clk
`timescale 1ns/10ps
module edpc_top
   import edpc_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
   input  wire logic           clk,       // 250 MHz clock
   input  wire logic           rst_n,     // async reset
   input  wire logic           hsel,      // slave select
   input  wire logic [31:0]    haddr,     // byte address
   input  wire logic [1:0]     htrans,    // transfer type
   input  wire logic           hwrite,    // write not read
   input  wire logic [2:0]     hsize,     // transfer size
   input  wire logic [31:0]    hwdata,    // write data
   input  wire logic           hready,    // bus ready
   output logic      [31:0]    hrdata,    // read data
   output logic                hreadyout, // slave ready
   output logic                hresp,     // always okay
   input  edpc_line_in_t       line_in,   // line events
   output edpc_line_out_t      line_out,  // line controls
   output logic                irq        // level interrupt
);

   edpc_state_t s_r;
   edpc_state_t s_nxt;

   logic            flip;
   logic            cnt_clr;
   logic            accept;
   logic            data_inc;
   logic            err_inc;
   logic            data_met;
   logic            dat_evt_hit;
   logic            err_evt_hit;
   logic            idle_to;
   logic            gap_tick;
   logic [TH_W-1:0] data_cnt;
   logic [TH_W-1:0] err_cnt;
   logic [ECR_W-1:0] ecr_view;

   // event strobes count only while sensing is on
   assign data_inc = s_r.ctl.enable && line_in.data_evt;
   assign err_inc  = s_r.ctl.enable && line_in.err_evt;

   // data event counter and threshold
   edpc_evcnt u_data_cnt (
      .clk   (clk),
      .rst_n (rst_n),
      .clr   (cnt_clr),
      .inc   (data_inc),
      .th    (s_r.ctl.data_th),
      .cnt   (data_cnt),
      .met   (data_met),
      .hit   (dat_evt_hit)
   );

   // error event counter and threshold
   edpc_evcnt u_err_cnt (
      .clk   (clk),
      .rst_n (rst_n),
      .clr   (cnt_clr),
      .inc   (err_inc),
      .th    (s_r.ctl.err_th),
      .cnt   (err_cnt),
      .met   (),
      .hit   (err_evt_hit)
   );

   // quiet-line timer, restarted by every data event
   edpc_tick #(
      .CYC (IDLE_CYCLES),
      .W   (IDLE_W)
   ) u_idle (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (data_inc == 1'b0 && s_r.ctl.enable),
      .tick  (idle_to)
   );

   // spacing of probe pulses after a wake
   edpc_tick #(
      .CYC (GAP_CYC),
      .W   (GAP_W)
   ) u_gap (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (s_r.pulses != 3'h0),
      .tick  (gap_tick)
   );

   // register image as software sees it
   assign ecr_view = {
      s_r.ctl.enable, s_r.ctl.wake, s_r.ctl.sleep, s_r.ctl.manual,
      s_r.ctl.burst_off,
      s_r.pwr == EDPC_ST_UP,  // RULE9
      s_r.err_hit, s_r.data_hit, s_r.ctl.err_th, s_r.ctl.data_th
   };

   // address phase is taken only for whole-word transfers
   assign accept = hsel && hready && htrans[1] && (hsize == SIZE_WORD);

   // power state decision from registered values and line_in.energy; kept out of
   // the next-state block so the counter clear forms no loop
   always_comb begin
      flip = 1'b0;
      if (s_r.ctl.enable) begin
         case (s_r.pwr)
            EDPC_ST_DOWN:
               flip = s_r.ctl.manual || (s_r.ctl.wake && data_met);  // RULE3
            EDPC_ST_UP:
               flip = s_r.ctl.manual || (s_r.ctl.sleep && !line_in.energy);  // RULE4
            default:
               flip = 1'b0;
         endcase
      end
   end

   // counters restart on quiet line, state change or disable
   assign cnt_clr = !s_r.ctl.enable || flip || idle_to;  // RULE14

   // next-state logic of the whole block
   always_comb begin
      s_nxt = s_r;

      // one-shot request is consumed every cycle
      s_nxt.ctl.manual = 1'b0;  // RULE16

      // probe pulse generation
      s_nxt.pulse = gap_tick;
      if (gap_tick) begin
         s_nxt.pulses = s_r.pulses - 3'h1;
      end

      // bus address phase; reads insert one wait state
      s_nxt.wr_pend = accept && hwrite;
      s_nxt.rd_pend = accept && !hwrite;
      s_nxt.hready  = !(accept && !hwrite);
      if (accept) begin
         s_nxt.ap_idx = haddr[31:2];
      end

      // write data phase
      if (s_r.wr_pend) begin
         if (s_r.ap_idx == ECR_IDX) begin
            s_nxt.ctl.enable    = hwdata[ENA_B];
            s_nxt.ctl.wake      = hwdata[WAKE_B];
            s_nxt.ctl.sleep     = hwdata[SLEEP_B];
            s_nxt.ctl.manual    = hwdata[MAN_B];
            s_nxt.ctl.burst_off = hwdata[BURST_B];
            s_nxt.ctl.err_th    = hwdata[ERRTH_L +: TH_W];  // RULE12
            s_nxt.ctl.data_th   = hwdata[DATTH_L +: TH_W];  // RULE13
         end else if (s_r.ap_idx == IST_IDX) begin
            s_nxt.int_st = s_r.int_st & ~hwdata[IRQ_W-1:0];
         end else if (s_r.ap_idx == IMK_IDX) begin
            s_nxt.int_mask = hwdata[IRQ_W-1:0];
         end
      end

      // read data phase, unmapped reads return zero
      if (s_r.rd_pend) begin
         s_nxt.hrdata = '0;
         if (s_r.ap_idx == ECR_IDX) begin
            s_nxt.hrdata[ECR_W-1:0] = ecr_view;
            s_nxt.err_hit  = 1'b0;  // RULE10
            s_nxt.data_hit = 1'b0;  // RULE11
         end else if (s_r.ap_idx == IST_IDX) begin
            s_nxt.hrdata[IRQ_W-1:0] = s_r.int_st;
         end else if (s_r.ap_idx == IMK_IDX) begin
            s_nxt.hrdata[IRQ_W-1:0] = s_r.int_mask;
         end
      end

      // manual request overrides thresholds and timer
      if (flip) begin  // RULE5
         s_nxt.int_st[IRQ_PWR] = 1'b1;  // RULE15
         if (s_r.pwr == EDPC_ST_DOWN) begin
            s_nxt.pwr    = EDPC_ST_UP;
            s_nxt.pulses = s_r.ctl.burst_off ? SINGLE_N : BURST_N;  // RULE7 RULE8
         end else begin
            s_nxt.pwr    = EDPC_ST_DOWN;
            s_nxt.pulses = 3'h0;
         end
      end

      // sensing off: logic parked down, no probing
      if (!s_r.ctl.enable) begin
         s_nxt.pwr    = EDPC_ST_DOWN;  // RULE1
         s_nxt.pulses = 3'h0;
      end

      // threshold flags; hardware set wins over read clear
      if (err_evt_hit) begin
         s_nxt.err_hit          = 1'b1;  // RULE10
         s_nxt.int_st[IRQ_ERR]  = 1'b1;
      end
      if (dat_evt_hit) begin
         s_nxt.data_hit         = 1'b1;  // RULE11
         s_nxt.int_st[IRQ_DAT]  = 1'b1;
      end

      // receiver runs normally whenever sensing is off
      s_nxt.rx_on = !s_nxt.ctl.enable || (s_nxt.pwr == EDPC_ST_UP);

      // level interrupt from unmasked sticky bits
      s_nxt.irq = |(s_nxt.int_st & s_nxt.int_mask);  // RULE15
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from state flops, hresp tied to okay
   assign hrdata            = s_r.hrdata;
   assign hreadyout         = s_r.hready;
   assign hresp             = HRESP_OKAY;
   assign irq               = s_r.irq;
   assign line_out.rx_power = s_r.rx_on;
   assign line_out.drv_on   = s_r.pwr == EDPC_ST_UP;
   assign line_out.pulse    = s_r.pulse;

   // checks on the block's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // step from down to up
   sequence seq_wake;
      s_r.ctl.enable && s_r.pwr == EDPC_ST_DOWN ##1 s_r.pwr == EDPC_ST_UP;
   endsequence

   // read data phase of the control register
   sequence seq_ecr_read;
      s_r.rd_pend && s_r.ap_idx == ECR_IDX ##1 1'b1;
   endsequence

   a_disabled_down: assert property ( // RULE1
      !s_r.ctl.enable |=> s_r.pwr == EDPC_ST_DOWN && s_r.pulses == 3'h0
   ) else $error("power state not parked while disabled");

   a_auto_wake: assert property ( // RULE3
      s_r.ctl.enable && s_r.ctl.wake && s_r.pwr == EDPC_ST_DOWN && data_met
      |=> s_r.pwr == EDPC_ST_UP
   ) else $error("no wake at data threshold");

   a_auto_sleep: assert property ( // RULE4
      s_r.ctl.enable && s_r.ctl.sleep && s_r.pwr == EDPC_ST_UP
      && !line_in.energy && !s_r.ctl.manual |=> s_r.pwr == EDPC_ST_DOWN
   ) else $error("no sleep without energy");

   a_manual_flip: assert property ( // RULE5
      s_r.ctl.enable && s_r.ctl.manual |=> s_r.pwr != $past(s_r.pwr)
   ) else $error("manual toggle did not change state");

   a_manual_clear: assert property ( // RULE16
      s_r.ctl.manual && !s_r.wr_pend |=> !s_r.ctl.manual
   ) else $error("manual bit not self-cleared");

   a_burst_four: assert property ( // RULE7
      !s_r.ctl.burst_off ##0 seq_wake |-> s_r.pulses == BURST_N
   ) else $error("burst of four not loaded on wake");

   a_single_pulse: assert property ( // RULE8
      s_r.ctl.burst_off ##0 seq_wake |-> s_r.pulses == SINGLE_N
   ) else $error("single pulse not loaded on wake");

   a_state_read: assert property ( // RULE9
      seq_ecr_read |-> hrdata[PWR_B] == ($past(s_r.pwr) == EDPC_ST_UP)
   ) else $error("power state bit reads wrong");

   a_err_read_clr: assert property ( // RULE10
      s_r.rd_pend && s_r.ap_idx == ECR_IDX && !err_evt_hit |=> !s_r.err_hit
   ) else $error("error flag not cleared by read");

   a_data_read_clr: assert property ( // RULE11
      s_r.rd_pend && s_r.ap_idx == ECR_IDX && !dat_evt_hit |=> !s_r.data_hit
   ) else $error("data flag not cleared by read");

   a_err_flag_set: assert property ( // RULE10
      err_evt_hit |=> s_r.err_hit && s_r.int_st[IRQ_ERR]
   ) else $error("error threshold hit not flagged");

   a_idle_clear: assert property ( // RULE14
      idle_to |=> data_cnt == '0 && err_cnt == '0
   ) else $error("counters not reset after quiet time");

   a_pwr_irq: assert property ( // RULE15
      $changed(s_r.pwr) && $past(s_r.ctl.enable) |-> s_r.int_st[IRQ_PWR]
   ) else $error("power change not latched as interrupt");

   a_irq_level: assert property ( // RULE15
      s_r.int_st[IRQ_PWR] && s_r.int_mask[IRQ_PWR] |-> irq
   ) else $error("unmasked power interrupt not on irq");

   a_enable_write: assert property ( // RULE1
      s_r.wr_pend && s_r.ap_idx == ECR_IDX |=> s_r.ctl.enable == $past(hwdata[ENA_B])
   ) else $error("enable bit not taken from write");

   a_disabled_counts: assert property ( // RULE1
      !s_r.ctl.enable |=> data_cnt == '0 && err_cnt == '0
   ) else $error("event counters run while disabled");

   a_err_no_wake: assert property ( // RULE10
      s_r.ctl.enable && s_r.pwr == EDPC_ST_DOWN && !s_r.ctl.manual && !data_met
      |=> s_r.pwr == EDPC_ST_DOWN
   ) else $error("woke without data threshold or manual request");

   a_data_flag_set: assert property ( // RULE11
      dat_evt_hit |=> s_r.data_hit && s_r.int_st[IRQ_DAT]
   ) else $error("data threshold hit not flagged");

   a_err_th_write: assert property ( // RULE12
      s_r.wr_pend && s_r.ap_idx == ECR_IDX
      |=> s_r.ctl.err_th == $past(hwdata[ERRTH_L +: TH_W])
   ) else $error("error threshold not taken from write");

   a_data_th_write: assert property ( // RULE13
      s_r.wr_pend && s_r.ap_idx == ECR_IDX
      |=> s_r.ctl.data_th == $past(hwdata[DATTH_L +: TH_W])
   ) else $error("data threshold not taken from write");

   a_down_no_probe: assert property ( // RULE7
      s_r.pwr == EDPC_ST_DOWN |-> s_r.pulses == 3'h0
   ) else $error("probe pulses pending while powered down");

   a_probe_step: assert property ( // RULE7
      gap_tick && s_r.ctl.enable && !flip
      |=> line_out.pulse && s_r.pulses == $past(s_r.pulses) - 3'h1
   ) else $error("probe pulse did not count down");

   a_state_clears: assert property ( // RULE14
      flip |=> data_cnt == '0 && err_cnt == '0
   ) else $error("counters kept across a power change");

   a_rx_parked: assert property ( // RULE4
      s_r.ctl.enable && s_r.pwr == EDPC_ST_DOWN |-> !line_out.rx_power
   ) else $error("receive path powered while sensing down");

endmodule // edpc_top
